//--- hw/csr_defs.svh
// constants for the capture stop and re-arm sequencer
// assumes a 100 MHz system clock; included by the sequencer and the testbench
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH
`define CSR_MEM_DEPTH       16384
`define CSR_STOP_DELAY_MAX  14'h3FFF
`define CSR_STOP_DELAY_RST  14'h3FFF
`define CSR_TRG_DELAY_RST   16'h0000
`define CSR_TRG_COUNT_RST   5'h01
// re-arm field resets to off, everything else cleared
`define CSR_CTRL_RST        32'h0000_0060
`define CSR_CLK_HZ          100000000
`define CSR_REARM_1S_SEC    1
`define CSR_REARM_3S_SEC    3
`define CSR_REARM_1S_CYC    (`CSR_REARM_1S_SEC * `CSR_CLK_HZ)
`define CSR_REARM_3S_CYC    (`CSR_REARM_3S_SEC * `CSR_CLK_HZ)
// register word addresses
`define CSR_ADDR_CTRL       4'h0
`define CSR_ADDR_STOP       4'h1
`define CSR_ADDR_TRIG       4'h2
`define CSR_ADDR_CMD        4'h3
`define CSR_ADDR_STATUS     4'h4
`define CSR_ADDR_COUNT      4'h5
// ctrl fields
`define CSR_CTRL_MODE_LSB   0
`define CSR_CTRL_STOP_LSB   2
`define CSR_CTRL_REARM_LSB  4
`define CSR_CTRL_SOE_BIT    8
`define CSR_CTRL_EXTEN_BIT  9
`define CSR_CTRL_GAPS_BIT   10
// command bits
`define CSR_CMD_RUN_BIT     0
`define CSR_CMD_STOP_BIT    1
`define CSR_CMD_SAMPLE_BIT  2
`endif

//--- hw/csr_pkg.sv
// types for the capture stop and re-arm sequencer
// assumes csr_defs.svh holds every numeric constant
package csr_pkg;
  typedef enum logic [1:0] {MODE_START_ANA, MODE_STOP_ANA, MODE_START_CMP} csr_mode_e;
  typedef enum logic [1:0] {STOP_RISE, STOP_FALL, STOP_INTERNAL, STOP_OFF} csr_stop_e;
  typedef enum logic [2:0]
  {
    REARM_0S, REARM_1S, REARM_3S, REARM_0S_ERR, REARM_1S_ERR, REARM_3S_ERR, REARM_OFF
  } csr_rearm_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ACTIVE} csr_state_e;
  typedef struct packed
  {
    logic        match;   // trigger word matched this clock
    logic        qual;    // trigger qualifier valid
    logic        arm;     // external arm level
    logic        mismatch;// compare error this clock
  } csr_dut_s;
endpackage

//--- hw/csr_sequencer.sv
// capture stop and re-arm sequencer with avalon-mm registers
// assumes match/qual/mismatch come from same-clock compare logic; stop and
// sample clock pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_sequencer #(
  parameter int unsigned REARM_1S_CYC = `CSR_REARM_1S_CYC,
  parameter int unsigned REARM_3S_CYC = `CSR_REARM_3S_CYC,
  parameter int unsigned MEM_DEPTH    = `CSR_MEM_DEPTH
) (
  input  wire logic             clk_i,            // 100 MHz system clock
  input  wire logic             reset_n_i,        // async reset, active low
  input  wire logic [3:0]       avs_address_i,    // word address
  input  wire logic             avs_read_i,       // read request
  input  wire logic             avs_write_i,      // write request
  input  wire logic [31:0]      avs_writedata_i,  // write data
  output logic      [31:0]      avs_readdata_o,   // read data
  output logic                  avs_waitrequest_o,// stall
  input  wire csr_pkg::csr_dut_s dut_i,           // same-clock compare results
  input  wire logic             samp_clk_i,       // link sampling clock pin
  input  wire logic             stop_pin_i,       // external stop pin
  output logic      [1:0]       state_o,          // idle/armed/active
  output logic                  capture_o,        // sample strobe this clock
  output logic                  error_seen_o      // compare error latched
);
  // ==========================================================
  // synchronisers and edge detect
  logic [2:0] samp_sync_reg;
  logic [2:0] stop_sync_reg;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      samp_sync_reg <= 3'h0;
      stop_sync_reg <= 3'h0;
    end
    else
    begin
      samp_sync_reg <= {samp_sync_reg[1:0], samp_clk_i};
      stop_sync_reg <= {stop_sync_reg[1:0], stop_pin_i};
    end
  end
  wire samp_tick = samp_sync_reg[1] & ~samp_sync_reg[2];
  wire stop_rise = stop_sync_reg[1] & ~stop_sync_reg[2];
  wire stop_fall = ~stop_sync_reg[1] & stop_sync_reg[2];

  // ==========================================================
  // registers
  logic [31:0] ctrl_reg;
  logic [13:0] stop_delay_reg;
  logic [15:0] trg_delay_reg;
  logic [4:0]  trg_count_reg;
  logic        run_cmd, stop_cmd, sample_cmd;
  logic        rd_pend_reg;
  csr_pkg::csr_state_e state_reg;
  logic [14:0] words_reg;
  logic        err_reg;

  wire csr_pkg::csr_mode_e  mode  = csr_pkg::csr_mode_e'(ctrl_reg[`CSR_CTRL_MODE_LSB +: 2]);
  wire csr_pkg::csr_stop_e  ssrc  = csr_pkg::csr_stop_e'(ctrl_reg[`CSR_CTRL_STOP_LSB +: 2]);
  wire csr_pkg::csr_rearm_e rearm =
    csr_pkg::csr_rearm_e'(ctrl_reg[`CSR_CTRL_REARM_LSB +: 3]);
  wire soe   = ctrl_reg[`CSR_CTRL_SOE_BIT];
  wire exten = ctrl_reg[`CSR_CTRL_EXTEN_BIT];
  wire gaps  = ctrl_reg[`CSR_CTRL_GAPS_BIT];

  // a write lands only on the edge at which the master sees waitrequest low,
  // so a master that gives up early can never leave a half-applied command
  wire wr_hit = avs_write_i & ~avs_waitrequest_o;
  // writes finish in one stall cycle; reads in two
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg       <= `CSR_CTRL_RST;
      stop_delay_reg <= `CSR_STOP_DELAY_RST;
      trg_delay_reg  <= `CSR_TRG_DELAY_RST;
      trg_count_reg  <= `CSR_TRG_COUNT_RST;
      run_cmd        <= 1'b0;
      stop_cmd       <= 1'b0;
      sample_cmd     <= 1'b0;
    end
    else
    begin
      run_cmd    <= 1'b0;
      stop_cmd   <= 1'b0;
      sample_cmd <= 1'b0;
      if (wr_hit)
      begin
        unique case (avs_address_i)
          `CSR_ADDR_CTRL: ctrl_reg <= {21'h0, avs_writedata_i[10:0]};
          `CSR_ADDR_STOP: stop_delay_reg <= avs_writedata_i[13:0];
          `CSR_ADDR_TRIG:
          begin
            trg_delay_reg <= avs_writedata_i[15:0];
            if (avs_writedata_i[20:16] >= 5'h01 && avs_writedata_i[20:16] <= 5'h10)
              trg_count_reg <= avs_writedata_i[20:16];
          end
          `CSR_ADDR_CMD:
          begin
            run_cmd    <= avs_writedata_i[`CSR_CMD_RUN_BIT];
            stop_cmd   <= avs_writedata_i[`CSR_CMD_STOP_BIT];
            sample_cmd <= avs_writedata_i[`CSR_CMD_SAMPLE_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      rd_pend_reg       <= 1'b0;
    end
    else
    begin
      avs_waitrequest_o <= 1'b1;
      rd_pend_reg       <= 1'b0;
      if (avs_write_i && avs_waitrequest_o)
        avs_waitrequest_o <= 1'b0;
      if (avs_read_i && avs_waitrequest_o && !rd_pend_reg)
        rd_pend_reg <= 1'b1;
      if (rd_pend_reg && avs_read_i)
      begin
        avs_waitrequest_o <= 1'b0;
        unique case (avs_address_i)
          `CSR_ADDR_CTRL:   avs_readdata_o <= ctrl_reg;
          `CSR_ADDR_STOP:   avs_readdata_o <= {18'h0, stop_delay_reg};
          `CSR_ADDR_TRIG:   avs_readdata_o <= {11'h0, trg_count_reg, trg_delay_reg};
          `CSR_ADDR_STATUS: avs_readdata_o <= {29'h0, err_reg, state_reg};
          `CSR_ADDR_COUNT:  avs_readdata_o <= {17'h0, words_reg};
          default:          avs_readdata_o <= 32'h0000_0000;
        endcase
      end
      if (!avs_waitrequest_o)
        avs_waitrequest_o <= 1'b1;
    end
  end

  // ==========================================================
  // trigger detection
  logic [4:0]  hit_cnt_reg;
  logic [16:0] tdly_reg;
  logic        tdly_run_reg;
  logic [14:0] sdly_reg;
  logic        sdly_run_reg;
  logic [31:0] rearm_cnt_reg;
  logic        rearm_wait_reg;
  logic        arm_d_reg;

  wire qualified = dut_i.match & dut_i.qual;
  wire trig_hit  = samp_tick && qualified && (hit_cnt_reg + 5'h01 >= trg_count_reg);
  // count occurrences with or without gaps
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hit_cnt_reg <= 5'h00;
    else if (state_reg == csr_pkg::ST_IDLE || trig_hit)
      hit_cnt_reg <= 5'h00;
    else if (samp_tick)
    begin
      if (qualified)
        hit_cnt_reg <= hit_cnt_reg + 5'h01;
      else if (!gaps)
        hit_cnt_reg <= 5'h00;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      arm_d_reg <= 1'b0;
    else
      arm_d_reg <= dut_i.arm;
  end
  wire ext_arm = exten & dut_i.arm & ~arm_d_reg;

  // ==========================================================
  // end conditions
  wire mem_full = (words_reg == 15'(MEM_DEPTH));
  // halt on the tick that shows the mismatch
  wire err_stop = soe && (mode == csr_pkg::MODE_START_CMP) && dut_i.mismatch && samp_tick;
  wire stop_mode = (mode == csr_pkg::MODE_STOP_ANA);
  wire trig_load = trig_hit && !tdly_run_reg &&
    (stop_mode ? state_reg == csr_pkg::ST_ACTIVE : state_reg == csr_pkg::ST_ARMED);
  // stop-analysis ends when the trigger delay runs out, unless memory fills or a stop or sample command comes first
  // a delay of d ends d ticks after the trigger word; zero ends on the word
  // itself, so the last count is taken as the counter reaches one
  wire tdly_done = samp_tick && ((tdly_run_reg && tdly_reg == 17'h1) ||
                                 (trig_load && trg_delay_reg == 16'h0));
  wire sdly_done = sdly_run_reg && samp_tick && (sdly_reg == 15'h0);
  wire cap_end = (state_reg == csr_pkg::ST_ACTIVE) &&
    (stop_cmd || (samp_tick && mem_full) ||
     (stop_mode ? tdly_done : (sdly_done || err_stop)));
  wire err_rearm = (rearm == csr_pkg::REARM_0S_ERR || rearm == csr_pkg::REARM_1S_ERR ||
                    rearm == csr_pkg::REARM_3S_ERR);
  wire rearm_ok = !(err_rearm && (err_reg || dut_i.mismatch));
  wire zero_rearm = rearm_ok && (rearm == csr_pkg::REARM_0S || rearm == csr_pkg::REARM_0S_ERR);

  // ==========================================================
  // state machine
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= csr_pkg::ST_IDLE;
    else
      unique case (state_reg)
        csr_pkg::ST_IDLE:
          if (sample_cmd)
            state_reg <= csr_pkg::ST_ACTIVE;
          else if (run_cmd || ext_arm ||
                   (rearm_wait_reg && rearm_cnt_reg == 32'h0))
            state_reg <= csr_pkg::ST_ARMED;
        csr_pkg::ST_ARMED:
          if (stop_cmd)
            state_reg <= csr_pkg::ST_IDLE;
          else if (stop_mode || sample_cmd)
            state_reg <= csr_pkg::ST_ACTIVE;
          else if (tdly_done)
            state_reg <= csr_pkg::ST_ACTIVE;
        csr_pkg::ST_ACTIVE:
          if (cap_end || (stop_mode && sample_cmd))
            state_reg <= (zero_rearm && !stop_cmd) ? csr_pkg::ST_ARMED : csr_pkg::ST_IDLE;
        default: state_reg <= csr_pkg::ST_IDLE;
      endcase
  end

  // trigger delay: runs in armed for start modes, in active for stop-analysis
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tdly_reg     <= 17'h0;
      tdly_run_reg <= 1'b0;
    end
    else if (state_reg == csr_pkg::ST_IDLE || cap_end)
      tdly_run_reg <= 1'b0;
    else if (trig_hit && !tdly_run_reg &&
             (stop_mode ? state_reg == csr_pkg::ST_ACTIVE : state_reg == csr_pkg::ST_ARMED))
    begin
      tdly_reg     <= {1'b0, trg_delay_reg};
      tdly_run_reg <= 1'b1;
    end
    else if (tdly_run_reg && samp_tick && tdly_reg != 17'h0)
      tdly_reg <= tdly_reg - 17'h1;
    else if (state_reg == csr_pkg::ST_ACTIVE && !stop_mode)
      tdly_run_reg <= 1'b0;
  end

  // stop delay counter; zero delay ends on the first tick after the edge, internal zero never runs
  wire enter_active = (state_reg != csr_pkg::ST_ACTIVE) &&
                      ((state_reg == csr_pkg::ST_ARMED && (stop_mode || tdly_done)) ||
                       sample_cmd);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sdly_reg     <= 15'h0;
      sdly_run_reg <= 1'b0;
    end
    else if (enter_active)
    begin
      // internal starts on active; loaded from setting
      sdly_reg     <= {1'b0, stop_delay_reg} - 15'h1;
      sdly_run_reg <= (ssrc == csr_pkg::STOP_INTERNAL) && (stop_delay_reg != 14'h0);
    end
    else if (state_reg != csr_pkg::ST_ACTIVE || cap_end)
      sdly_run_reg <= 1'b0;
    // chosen edge; external counts after edge
    else if (!sdly_run_reg &&
             ((ssrc == csr_pkg::STOP_RISE && stop_rise) ||
              (ssrc == csr_pkg::STOP_FALL && stop_fall)))
    begin
      // edge-to-stop equals setting, one tick for zero
      // the word on the ending tick is the last one of the count
      sdly_reg     <= (stop_delay_reg == 14'h0) ? 15'h0 : {1'b0, stop_delay_reg} - 15'h1;
      sdly_run_reg <= 1'b1;
    end
    else if (sdly_run_reg && samp_tick)
      sdly_reg <= sdly_reg - 15'h1;
  end
  // stop off relies on memory full, a stop command or an error stop; delay unused
  // memory full ends capture without an edge

  // captured words and error flag
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      words_reg <= 15'h0;
    else if (enter_active)
      words_reg <= 15'h0;
    else if (state_reg == csr_pkg::ST_ACTIVE && samp_tick && !mem_full)
      words_reg <= words_reg + 15'h1;
  end

  // errors only count in compare mode
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      err_reg <= 1'b0;
    else if (state_reg == csr_pkg::ST_ACTIVE && samp_tick && dut_i.mismatch &&
             mode == csr_pkg::MODE_START_CMP)
      err_reg <= 1'b1;
    else if (run_cmd)
      err_reg <= 1'b0;
  end

  // ==========================================================
  // timed re-arm
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rearm_cnt_reg  <= 32'h0;
      rearm_wait_reg <= 1'b0;
    end
    else if (cap_end && rearm_ok && !zero_rearm && !stop_cmd)
    begin
      // 1s/3s wait in idle; off never waits
      unique case (rearm)
        csr_pkg::REARM_1S, csr_pkg::REARM_1S_ERR:
        begin
          rearm_cnt_reg  <= REARM_1S_CYC - 32'd2;
          rearm_wait_reg <= 1'b1;
        end
        csr_pkg::REARM_3S, csr_pkg::REARM_3S_ERR:
        begin
          rearm_cnt_reg  <= REARM_3S_CYC - 32'd2;
          rearm_wait_reg <= 1'b1;
        end
        default: rearm_wait_reg <= 1'b0;
      endcase
    end
    else if (state_reg != csr_pkg::ST_IDLE || run_cmd)
      rearm_wait_reg <= 1'b0;
    else if (rearm_wait_reg && rearm_cnt_reg != 32'h0)
      rearm_cnt_reg <= rearm_cnt_reg - 32'h1;
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_o      <= 2'h0;
      capture_o    <= 1'b0;
      error_seen_o <= 1'b0;
    end
    else
    begin
      state_o      <= state_reg;
      capture_o    <= (state_reg == csr_pkg::ST_ACTIVE) && samp_tick && !mem_full;
      error_seen_o <= err_reg;
    end
  end
endmodule

//--- verification/csr_sequencer_asserts.sv
// port-level assertions for the capture stop and re-arm sequencer
// assumes it is bound to csr_sequencer; sampling ticks lie 16 clocks apart
`timescale 1ns/1ps
module csr_sequencer_asserts (
  input  wire logic              clk_i,             // clock
  input  wire logic              reset_n_i,         // reset, active low
  input  wire logic              avs_read_i,        // read request
  input  wire logic              avs_write_i,       // write request
  input  wire logic [31:0]       avs_readdata_o,    // read data
  input  wire logic              avs_waitrequest_o, // stall
  input  wire csr_pkg::csr_dut_s dut_i,             // compare results
  input  wire logic [1:0]        state_o,           // sequencer state
  input  wire logic              capture_o,         // word strobe
  input  wire logic              error_seen_o       // error flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ====================
  // bus handshake
  sequence s_rd_walk;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  property p_wr_ans;
    avs_write_i && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered on the next cycle");
  property p_rd_ans;
    $rose(avs_read_i) |=> s_rd_walk;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered two cycles later");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
  property p_rd_hold;
    !avs_read_i && !$past(avs_read_i) |-> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  // ====================
  // capture window
  sequence s_left_active;
    state_o == 2'h2 ##1 state_o != 2'h2;
  endsequence
  property p_cap_active;
    capture_o |-> state_o == 2'h2 || $past(state_o) == 2'h2;
  endproperty
  a_cap_active: assert property (p_cap_active)
    else $error("word stored outside the active state");
  property p_cap_pulse;
    capture_o |=> !capture_o [*8];
  endproperty
  a_cap_pulse: assert property (p_cap_pulse)
    else $error("more than one word for one sampling edge");
  property p_cap_after_end;
    s_left_active |=> !capture_o [*8];
  endproperty
  a_cap_after_end: assert property (p_cap_after_end)
    else $error("word stored after capture ended");
  // ====================
  // compare errors
  property p_err_cause;
    $rose(error_seen_o) |->
      $past(dut_i.mismatch, 1) || $past(dut_i.mismatch, 2) || $past(dut_i.mismatch, 3);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error flag set without a mismatch");
endmodule

//--- verification/csr_dut_model.sv
// pattern source model: sampling clock, stop pin and compare results
// assumes the bench sets levels; they are applied at sampling clock falls
`timescale 1ns/1ps
module csr_dut_model (
  input  wire logic         run_i,      // let the sampling clock run
  input  wire logic         match_i,    // match level to present
  input  wire logic         mis_i,      // mismatch level to present
  input  wire logic         stop_i,     // stop pin level to present
  output logic              samp_clk_o, // sampling clock, 160 ns
  output logic              stop_pin_o, // stop pin
  output csr_pkg::csr_dut_s dut_o       // match, qualifier, arm, mismatch
);
  // odd start offset keeps the two clocks unrelated in phase
  initial
  begin
    samp_clk_o = 1'b0;
    stop_pin_o = 1'b0;
    dut_o      = '0;
    #3;
    forever
    begin
      #80;
      // clock stands still low between frames
      if (run_i || samp_clk_o)
        samp_clk_o = ~samp_clk_o;
    end
  end
  // data changes mid-period, far from the edge the sequencer samples on
  always @(negedge samp_clk_o)
  begin
    dut_o      <= '{match: match_i, qual: 1'b1, arm: 1'b0, mismatch: mis_i};
    stop_pin_o <= stop_i;
  end
endmodule

//--- verification/testbench.sv
// self-checking bench for the capture stop and re-arm sequencer
// assumes csr_dut_model as pattern source; long counts cut down by parameters
`timescale 1ns/1ps
`include "csr_defs.svh"
module testbench;
  localparam int MEM = 32;
  localparam int R1S = 50;
  logic              clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic              capture_o, error_seen_o, samp, stop_pin, run, match, mis, stop_lvl;
  logic [3:0]        avs_address_i;
  logic [31:0]       avs_writedata_i, avs_readdata_o, q, rng;
  logic [1:0]        state_o;
  csr_pkg::csr_dut_s dut;
  int                n_mismatch, num_checks, n_cap, n_idle, base, t, exp_w, i0;
  // ====================
  // clock, instances, monitors
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  csr_sequencer #(.REARM_1S_CYC(R1S), .REARM_3S_CYC(2 * R1S), .MEM_DEPTH(MEM)) DUT (
    .clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .dut_i(dut), .samp_clk_i(samp),
    .stop_pin_i(stop_pin), .state_o, .capture_o, .error_seen_o);
  csr_dut_model u_src (.run_i(run), .match_i(match), .mis_i(mis), .stop_i(stop_lvl),
    .samp_clk_o(samp), .stop_pin_o(stop_pin), .dut_o(dut));
  always @(posedge clk_i)
  begin
    if (capture_o === 1'b1)
      n_cap <= n_cap + 1;
    if (state_o === 2'h0)
      n_idle <= n_idle + 1;
  end
  // ====================
  // tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (k == 50)
      n_mismatch++;
    @(posedge clk_i);
  endtask
  task automatic go(input logic [1:0] md, sp, input logic [2:0] ra, input logic soe,
                    input logic [13:0] sd, input logic [15:0] td);
    bus(1'b1, `CSR_ADDR_CTRL, {23'h0, soe, 1'b0, ra, sp, md});
    bus(1'b1, `CSR_ADDR_STOP, {18'h0, sd});
    bus(1'b1, `CSR_ADDR_TRIG, {11'h0, 5'h01, td});
    run <= 1'b1;
    base = n_cap;
    bus(1'b1, `CSR_ADDR_CMD, 32'h0000_0001);
  endtask
  task automatic wait_st(input logic [1:0] s);
    t = 0;
    while (state_o !== s && t < 3000)
    begin
      @(posedge clk_i);
      t++;
    end
    if (t == 3000)
      n_mismatch++;
  endtask
  // one change at the source; the word count is noted at the fall that applies it
  task automatic poke(input int s);
    if (s == 0)
      match <= 1'b1;
    else if (s == 1)
      mis <= 1'b1;
    else
      stop_lvl <= ~stop_lvl;
    @(negedge samp);
    base = n_cap;
    @(posedge clk_i);
    if (s == 0)
      match <= 1'b0;
    if (s == 1)
      mis <= 1'b0;
  endtask
  task automatic endc(input string nm);
    bus(1'b1, `CSR_ADDR_CMD, 32'h0000_0002);
    wait_st(2'h0);
    run <= 1'b0;
    $display("test %s done", nm);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // scenarios
  initial
  begin
    {avs_read_i, avs_write_i, run, match, mis, stop_lvl} = 6'h00;
    avs_address_i   = 4'h0;
    avs_writedata_i = 32'h0;
    reset_n_i       = 1'b0;
    rng             = 32'h0001_11A8;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk(state_o, 2'h0);
    bus(1'b0, `CSR_ADDR_CTRL, 32'h0);
    chk(q, 32'h0000_0060);
    bus(1'b0, `CSR_ADDR_STOP, 32'h0);
    chk(q, 32'h0000_3FFF);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b1, `CSR_ADDR_TRIG, 32'h0010_0000);
    bus(1'b0, `CSR_ADDR_TRIG, 32'h0);
    chk(q, 32'h0010_0000);
    $display("test registers done");
    match <= 1'b1;
    repeat (3)
    begin
      rng = xs(rng);
      exp_w = 1 + rng % 20;
      go(csr_pkg::MODE_START_ANA, csr_pkg::STOP_INTERNAL, csr_pkg::REARM_OFF, 1'b0,
         exp_w[13:0], 16'h0);
      wait_st(2'h2);
      wait_st(2'h0);
      chk(n_cap - base, exp_w);
      repeat (100) @(posedge clk_i);
      chk(state_o, 2'h0);
      bus(1'b0, `CSR_ADDR_COUNT, 32'h0);
      chk(q, exp_w);
      endc("internal stop");
    end
    for (int e = 0; e < 4; e++)
    begin
      // rise, fall, rise with no edge, stop off with an ignored delay
      go(csr_pkg::MODE_START_ANA, e == 3 ? 2'h3 : e[1:0] & 2'h1, csr_pkg::REARM_OFF,
         1'b0, 14'h000D, 16'h0);
      wait_st(2'h2);
      repeat (4) @(negedge samp);
      if (e < 2)
        poke(2);
      wait_st(2'h0);
      chk(n_cap - base, e < 2 ? 13 : MEM);
      endc("external stop");
    end
    match <= 1'b0;
    go(csr_pkg::MODE_STOP_ANA, csr_pkg::STOP_OFF, csr_pkg::REARM_OFF, 1'b0, 14'h0, 16'h0004);
    repeat (3) @(negedge samp);
    chk(state_o, 2'h2);
    poke(0);
    wait_st(2'h0);
    chk(n_cap - base, 5);
    endc("stop on trigger");
    match <= 1'b1;
    go(csr_pkg::MODE_START_CMP, csr_pkg::STOP_OFF, csr_pkg::REARM_0S_ERR, 1'b1, 14'h0, 16'h0);
    wait_st(2'h2);
    repeat (3) @(negedge samp);
    poke(1);
    wait_st(2'h0);
    chk(n_cap - base <= 2, 1);
    repeat (200) @(posedge clk_i);
    chk({state_o, error_seen_o}, 3'h1);
    bus(1'b0, `CSR_ADDR_STATUS, 32'h0);
    chk(q[2:0], 3'h4);
    go(csr_pkg::MODE_START_CMP, csr_pkg::STOP_INTERNAL, csr_pkg::REARM_0S, 1'b0, 14'h2, 16'h0);
    wait_st(2'h2);
    i0 = n_idle;
    repeat (30) @(negedge samp);
    chk({n_idle - i0 == 0, error_seen_o, n_cap - base > 10}, 3'h5);
    endc("stop on error");
    go(csr_pkg::MODE_START_ANA, csr_pkg::STOP_INTERNAL, csr_pkg::REARM_OFF, 1'b1, 14'h6, 16'h0);
    wait_st(2'h2);
    i0 = base;
    @(negedge samp);
    poke(1);
    wait_st(2'h0);
    chk(n_cap - i0, 6);
    endc("error in analysis");
    for (int r = 1; r < 6; r++)
      if (r != 3)
      begin
        go(csr_pkg::MODE_START_ANA, csr_pkg::STOP_INTERNAL, r[2:0], 1'b0, 14'h2, 16'h0);
        wait_st(2'h2);
        wait_st(2'h0);
        wait_st(2'h1);
        exp_w = (r % 3 == 1) ? R1S : 2 * R1S;
        chk(t >= exp_w - 1 && t <= exp_w + 1, 1);
        endc("re-arm delay");
      end
    finish_test();
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
endmodule
bind csr_sequencer csr_sequencer_asserts u_chk (.clk_i, .reset_n_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .dut_i, .state_o, .capture_o, .error_seen_o);
